// [rtl/adc_mode_pkg.sv]
// package for the converter operating mode register block
// assumes an axi4-lite master with 32-bit data on the same clock
package adc_mode_pkg;
	localparam int          addr_w           = 8;
	localparam int          data_w           = 32;
	localparam logic [7:0]  mode_reg_index   = 8'h01;
	localparam logic [7:0]  mode_reg_addr    = 8'h04;
	localparam logic [15:0] mode_reset       = 16'h2000;
	localparam logic [15:0] mode_write_mask  = 16'he77c;
	localparam int          ref_en_bit       = 15;
	localparam int          spare_bit        = 14;
	localparam int          settled_bit      = 13;
	localparam int          delay_lsb        = 8;
	localparam int          opmode_lsb       = 4;
	localparam int          clksel_lsb       = 2;
	localparam logic [1:0]  resp_okay        = 2'b00;
	localparam logic [1:0]  resp_slverr      = 2'b10;
	localparam int          clk_mhz          = 50;
	// settling delays in microseconds, indexed by delay code
	localparam int          delay_us [8]     = '{0, 16, 64, 160, 400, 800, 3000, 4000};
	localparam int          cnt_w            = 18;

	typedef enum logic [2:0] {
		op_continuous = 3'h0, op_single = 3'h1, op_standby = 3'h2, op_power_down = 3'h3,
		op_int_offset = 3'h4, op_int_gain = 3'h5, op_sys_offset = 3'h6, op_sys_gain = 3'h7
	} op_mode_t;

	typedef enum logic [1:0] {
		clk_internal = 2'h0, clk_internal_out = 2'h1, clk_external = 2'h2, clk_crystal = 2'h3
	} clock_source_select_t;

	// gray codes along idle, settle, run
	typedef enum logic [1:0] {
		st_idle = 2'b00, st_settle = 2'b01, st_run = 2'b11
	} conv_state_t;

	typedef struct packed {
		logic                 reference_enable;
		logic                 settled_only_output;
		logic [2:0]           settle_code;
		op_mode_t             op_mode;
		clock_source_select_t clock_source_select;
	} mode_ctrl_t;

	function automatic logic [cnt_w-1:0] settle_cycles(input logic [2:0] code);
		settle_cycles = cnt_w'(delay_us[code] * clk_mhz);
	endfunction : settle_cycles
endpackage : adc_mode_pkg

// [rtl/adc_operating_mode.sv]
// operating mode register of the converter, with axi4-lite slave and control outputs
// assumes a single clock aclk and synchronous active-low reset
//
// What this block does
// - any write to the mode register resets filter, clears ready, starts new conversion or calibration
// - sixteen-bit register at address 0x01, reset value 0x2000
// - bit 15 enables internal reference, buffered 2.5 V on reference output pin
// - bit 13 with one channel active outputs only settled filter results
// - bits 10:8 pick post channel switch settling delay, 0 us to 4 ms
// - bits 6:4 pick continuous, single, standby, power-down or calibration modes
// - bits 3:2 pick internal, internal driven out, external clock or crystal
// - internal oscillator codes also turn the oscillator on
// - reserved bits read zero; bit 14 read-write, others read-only
`timescale 1ns/1ps
module adc_operating_mode
	import adc_mode_pkg::*;
(
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	// register bus
	input  wire logic [adc_mode_pkg::addr_w-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [adc_mode_pkg::data_w-1:0] s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [adc_mode_pkg::addr_w-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [adc_mode_pkg::data_w-1:0] s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	// converter side
	input  wire logic                       channel_switch,
	input  wire logic                       conversion_done,
	output adc_mode_pkg::mode_ctrl_t        mode_ctrl,
	output logic                            filter_reset,
	output logic                            ready_clear,
	output logic                            conversion_start,
	output logic                            input_processing,
	output logic                            internal_osc_enable,
	output logic                            clock_io_drive,
	output logic                            reference_output_enable
);
	import adc_mode_pkg::*;

	typedef struct packed {
		logic [15:0]              mode_reg;
		logic                     aw_held;
		logic [addr_w-1:0]        aw_addr;
		logic                     w_held;
		logic [data_w-1:0]        w_data;
		logic [3:0]               w_strb;
		logic                     bvalid;
		logic [1:0]               bresp;
		logic                     rvalid;
		logic [data_w-1:0]        rdata;
		logic [1:0]               rresp;
		conv_state_t              state;
		logic [cnt_w-1:0]         count;
		logic                     filter_reset;
		logic                     ready_clear;
		logic                     conversion_start;
		logic                     input_processing;
		logic                     osc_en;
		logic                     clk_out;
		logic                     ref_en;
	} state_t;

	state_t cur;
	state_t next_cur;

	function automatic mode_ctrl_t unpack_mode(input logic [15:0] r);
		unpack_mode.reference_enable    = r[ref_en_bit];
		unpack_mode.settled_only_output = r[settled_bit];
		unpack_mode.settle_code         = r[delay_lsb +: 3];
		unpack_mode.op_mode             = op_mode_t'(r[opmode_lsb +: 3]);
		unpack_mode.clock_source_select = clock_source_select_t'(r[clksel_lsb +: 2]);
	endfunction : unpack_mode

	// byte lanes 0 and 1 carry the sixteen register bits
	function automatic logic [15:0] merge_lanes(
		input logic [15:0]       old_value,
		input logic [data_w-1:0] new_data,
		input logic [3:0]        strb
	);
		merge_lanes = old_value;
		if (strb[0]) begin
			merge_lanes[7:0] = new_data[7:0];
		end
		if (strb[1]) begin
			merge_lanes[15:8] = new_data[15:8];
		end
		// read-only reserved bits stay zero
		merge_lanes = merge_lanes & mode_write_mask;
	endfunction : merge_lanes

	// the mode register answers at its byte address only
	function automatic logic address_hits(input logic [addr_w-1:0] addr);
		if (addr == mode_reg_addr) begin
			address_hits = 1'b1;
		end else begin
			address_hits = 1'b0;
		end
	endfunction : address_hits

	// only the mode register is mapped; the upper half reads zero
	function automatic logic [data_w-1:0] read_word(input logic [15:0] value);
		read_word       = '0;
		read_word[15:0] = value;
	endfunction : read_word

	////////////////////////////////////////////////////////////////////////////////
	// next state

	logic [15:0] wr_value;
	logic        do_write;
	logic        hit_write;
	logic        runs;
	mode_ctrl_t  ctl;

	always_comb begin
		next_cur                  = cur;
		next_cur.filter_reset     = 1'b0;
		next_cur.ready_clear      = 1'b0;
		next_cur.conversion_start = 1'b0;

		// address and data are held until both have arrived
		if (s_axi_awvalid && !cur.aw_held) begin
			next_cur.aw_held = 1'b1;
			next_cur.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !cur.w_held) begin
			next_cur.w_held = 1'b1;
			next_cur.w_data = s_axi_wdata;
			next_cur.w_strb = s_axi_wstrb;
		end
		if (cur.bvalid && s_axi_bready) begin
			next_cur.bvalid = 1'b0;
		end

		do_write  = cur.aw_held && cur.w_held && !cur.bvalid;
		hit_write = do_write && address_hits(cur.aw_addr);
		wr_value  = merge_lanes(cur.mode_reg, cur.w_data, cur.w_strb);

		if (do_write) begin
			next_cur.aw_held = 1'b0;
			next_cur.w_held  = 1'b0;
			next_cur.bvalid  = 1'b1;
			next_cur.bresp   = hit_write ? resp_okay : resp_slverr;
		end
		if (hit_write) begin
			next_cur.mode_reg         = wr_value;
			next_cur.filter_reset     = 1'b1;
			next_cur.ready_clear      = 1'b1;
			next_cur.conversion_start = 1'b1;
		end

		// reads return stored value only, no side effect
		if (cur.rvalid && s_axi_rready) begin
			next_cur.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !cur.rvalid) begin
			next_cur.rvalid = 1'b1;
			if (address_hits(s_axi_araddr)) begin
				next_cur.rdata = read_word(cur.mode_reg);
				next_cur.rresp = resp_okay;
			end else begin
				next_cur.rdata = '0;
				next_cur.rresp = resp_slverr;
			end
		end

		ctl  = unpack_mode(next_cur.mode_reg);
		case (ctl.op_mode)
			op_standby: begin
				runs = 1'b0;
			end
			op_power_down: begin
				runs = 1'b0;
			end
			default: begin
				runs = 1'b1;
			end
		endcase

		// settling delay after channel switch or restart
		case (cur.state)
			st_idle: begin
				next_cur.input_processing = 1'b0;
			end
			st_settle: begin
				next_cur.input_processing = 1'b0;
				if (cur.count == '0) begin
					next_cur.state            = st_run;
					next_cur.input_processing = 1'b1;
				end else begin
					next_cur.count = cur.count - 1'b1;
				end
			end
			st_run: begin
				if (conversion_done && (ctl.op_mode != op_continuous)) begin
					next_cur.state            = st_idle;
					next_cur.input_processing = 1'b0;
				end else if (channel_switch) begin
					next_cur.state            = st_settle;
					next_cur.count            = settle_cycles(ctl.settle_code);
					next_cur.input_processing = 1'b0;
				end
			end
			default: begin
				next_cur.state = st_idle;
			end
		endcase
		if (hit_write) begin
			next_cur.input_processing = 1'b0;
			if (runs) begin
				next_cur.state = st_settle;
				next_cur.count = settle_cycles(ctl.settle_code);
			end else begin
				next_cur.state = st_idle;
			end
		end

		// clock source and reference follow the stored fields
		case (ctl.clock_source_select)
			clk_internal: begin
				next_cur.osc_en  = 1'b1;
				next_cur.clk_out = 1'b0;
			end
			clk_internal_out: begin
				next_cur.osc_en  = 1'b1;
				next_cur.clk_out = 1'b1;
			end
			clk_external: begin
				next_cur.osc_en  = 1'b0;
				next_cur.clk_out = 1'b0;
			end
			clk_crystal: begin
				next_cur.osc_en  = 1'b0;
				next_cur.clk_out = 1'b0;
			end
			default: begin
				next_cur.osc_en  = 1'b1;
				next_cur.clk_out = 1'b0;
			end
		endcase
		if (ctl.reference_enable) begin
			next_cur.ref_en = 1'b1;
		end else begin
			next_cur.ref_en = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cur                  <= '0;
			cur.mode_reg         <= mode_reset;
			cur.aw_held          <= 1'b0;
			cur.w_held           <= 1'b0;
			cur.bvalid           <= 1'b0;
			cur.bresp            <= resp_okay;
			cur.rvalid           <= 1'b0;
			cur.rresp            <= resp_okay;
			cur.state            <= st_idle;
			cur.count            <= '0;
			cur.filter_reset     <= 1'b0;
			cur.ready_clear      <= 1'b0;
			cur.conversion_start <= 1'b0;
			cur.input_processing <= 1'b0;
			cur.osc_en           <= 1'b1;
			cur.clk_out          <= 1'b0;
			cur.ref_en           <= 1'b0;
		end else begin
			cur <= next_cur;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign s_axi_awready           = !cur.aw_held;
	assign s_axi_wready            = !cur.w_held;
	assign s_axi_bvalid            = cur.bvalid;
	assign s_axi_bresp             = cur.bresp;
	assign s_axi_arready           = !cur.rvalid;
	assign s_axi_rvalid            = cur.rvalid;
	assign s_axi_rdata             = cur.rdata;
	assign s_axi_rresp             = cur.rresp;
	assign mode_ctrl               = unpack_mode(cur.mode_reg);
	assign filter_reset            = cur.filter_reset;
	assign ready_clear             = cur.ready_clear;
	assign conversion_start        = cur.conversion_start;
	assign input_processing        = cur.input_processing;
	assign internal_osc_enable     = cur.osc_en;
	assign clock_io_drive          = cur.clk_out;
	assign reference_output_enable = cur.ref_en;
endmodule : adc_operating_mode

// [verification/mode_sva.sv]
// checker for the operating mode register block
// assumes it is bound to adc_operating_mode and sees only its ports
`timescale 1ns/1ps
module mode_sva
	import adc_mode_pkg::*;
(
	input wire logic                       aclk,
	input wire logic                       aresetn,
	input wire logic                       s_axi_bvalid,
	input wire logic                       s_axi_bready,
	input wire logic [1:0]                 s_axi_bresp,
	input wire logic                       s_axi_rvalid,
	input wire logic [1:0]                 s_axi_rresp,
	input wire logic [data_w-1:0]          s_axi_rdata,
	input wire adc_mode_pkg::mode_ctrl_t   mode_ctrl,
	input wire logic                       filter_reset,
	input wire logic                       ready_clear,
	input wire logic                       conversion_start,
	input wire logic                       internal_osc_enable,
	input wire logic                       clock_io_drive,
	input wire logic                       reference_output_enable
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////
	property p_restart;
		$rose(s_axi_bvalid) && s_axi_bresp == resp_okay
			|-> ##[0:1] (filter_reset && ready_clear && conversion_start);
	endproperty
	a_restart: assert property (p_restart) else $error("no restart after write");
	property p_pulse;
		filter_reset |=> !filter_reset;
	endproperty
	a_pulse: assert property (p_pulse) else $error("filter reset too long");
	property p_write_only;
		!$stable(mode_ctrl) |-> $rose(s_axi_bvalid) && s_axi_bresp == resp_okay;
	endproperty
	a_write_only: assert property (p_write_only) else $error("mode changed without write");
	property p_reset_val;
		$rose(aresetn) |-> mode_ctrl == 10'h100;
	endproperty
	a_reset_val: assert property (p_reset_val) else $error("bad reset value");
	property p_ref;
		reference_output_enable == mode_ctrl.reference_enable;
	endproperty
	a_ref: assert property (p_ref) else $error("reference enable mismatch");
	property p_osc;
		internal_osc_enable == !mode_ctrl.clock_source_select[1];
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator enable mismatch");
	property p_clkio;
		clock_io_drive == (mode_ctrl.clock_source_select == clk_internal_out);
	endproperty
	a_clkio: assert property (p_clkio) else $error("clock pin drive mismatch");
	property p_rsvd;
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0 && s_axi_rdata[12:11] == 2'h0
			&& !s_axi_rdata[7] && s_axi_rdata[1:0] == 2'h0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
endmodule : mode_sva

// [verification/tb_top.sv]
// bench for the operating mode register block
// assumes axi4-lite access and the mode_sva checker bound below
`timescale 1ns/1ps
module tb_top;
	import adc_mode_pkg::*;
	logic        aclk, aresetn, awv, wv, arv, sw, done;
	logic        awready, wready, bvalid, arready, rvalid, fr, rc, cs, ip, osc, cio, ref_en;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [1:0]  bresp, rresp, r;
	mode_ctrl_t  mode_ctrl;
	int          errors = 0, check_count = 0, n;
	adc_operating_mode uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
		.s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
		.channel_switch(sw), .conversion_done(done), .mode_ctrl(mode_ctrl),
		.filter_reset(fr), .ready_clear(rc), .conversion_start(cs), .input_processing(ip),
		.internal_osc_enable(osc), .clock_io_drive(cio), .reference_output_enable(ref_en));
	////////////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] v);
		awaddr <= a;
		wdata <= v;
		awv <= 1'b1;
		wv <= 1'b1;
		do begin
			@(posedge aclk);
			if (awv && awready) awv <= 1'b0;
			if (wv && wready) wv <= 1'b0;
		end while (!bvalid);
		r = bresp;
	endtask : wr
	task rd(input logic [7:0] a);
		araddr <= a;
		arv <= 1'b1;
		do begin
			@(posedge aclk);
			if (arv && arready) arv <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
	endtask : rd
	task tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////////////
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		errors++;
		tally_and_finish();
	end
	initial begin
		{aresetn, awv, wv, arv, sw, done, awaddr, araddr, wdata} = '0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(8'h04);
		chk("reset value", d, 32'h2000);
		wr(8'h04, 32'hffff);
		rd(8'h04);
		chk("masked value", d, 32'he77c);
		chk("reference", ref_en, 1);
		$display("register access test done");
		for (int i = 0; i < 4; i++) begin
			wr(8'h04, i << 2);
			chk("oscillator", osc, i < 2);
			chk("clock pin", cio, i == 1);
		end
		for (int i = 0; i < 8; i++) begin
			wr(8'h04, (i << 8) | (i << 4));
			chk("mode ctrl", 32'(mode_ctrl), (i << 5) | (i << 2));
			rd(8'h04);
			chk("fields", d, (i << 8) | (i << 4));
		end
		$display("field test done");
		wr(8'h04, 32'h0100);
		n = 0;
		while (!ip && n < 2000) begin
			@(posedge aclk);
			n++;
		end
		chk("settle count", n >= 795 && n <= 805, 1);
		sw <= 1'b1;
		@(posedge aclk);
		sw <= 1'b0;
		repeat (2) @(posedge aclk);
		chk("resettle", ip, 0);
		wr(8'h04, 32'h0010);
		repeat (3) @(posedge aclk);
		done <= 1'b1;
		@(posedge aclk);
		done <= 1'b0;
		repeat (2) @(posedge aclk);
		chk("single ends", ip, 0);
		$display("conversion test done");
		wr(8'h08, 32'h8000);
		chk("write resp", r, 2'b10);
		rd(8'h04);
		chk("unchanged", d, 32'h0010);
		rd(8'h08);
		chk("read resp", r, 2'b10);
		chk("read data", d, 0);
		$display("unmapped test done");
		tally_and_finish();
	end
endmodule : tb_top
bind adc_operating_mode mode_sva chk_i (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
	.s_axi_bresp, .s_axi_rvalid, .s_axi_rresp, .s_axi_rdata, .mode_ctrl, .filter_reset,
	.ready_clear, .conversion_start, .internal_osc_enable, .clock_io_drive,
	.reference_output_enable);
